// file: src/psr_pkg.sv
/*
  Shared constants and types for the power, sleep and reset control block.
  Assumes a single 100 MHz clock and a word-aligned Avalon-MM register port.
*/
`default_nettype none
package psr_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] PSC_IDX = 8'h35;
  localparam logic [7:0] MCG_IDX = 8'h36;
  localparam logic [9:0] PSC_ADDR = {PSC_IDX, 2'b00};
  localparam logic [9:0] MCG_ADDR = {MCG_IDX, 2'b00};
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam logic [7:0] MCG_RESET = 8'h00;
  // Synchroniser reset levels {por, external pin, brownout}; the pin idles high
  localparam logic [2:0] PIN_SYNC_RESET = 3'h2;
  // Bits stored as written; bits 7 and 2 go through the timed sequence
  localparam logic [7:0] PSC_PLAIN_MASK = 8'h7b;
  localparam logic [7:0] MCG_WR_MASK = 8'h0f;
  localparam int PSC_BRN_OFF_BIT = 7;
  localparam int PSC_SLEEP_EN_BIT = 5;
  localparam int PSC_SM_HI = 4;
  localparam int PSC_SM_LO = 3;
  localparam int PSC_UNLOCK_BIT = 2;
  localparam int MCG_TIMER1_BIT = 3;
  localparam int MCG_TIMER0_BIT = 2;
  localparam int MCG_SERIAL_BIT = 1;
  localparam int MCG_CONV_BIT = 0;
  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam logic [2:0] BRN_OFF_WINDOW_CYC = 3'h4;
  localparam logic [2:0] BRN_OFF_DELAY_CYC = 3'h3;
  localparam logic [2:0] BRN_OFF_HOLD_CYC = 3'h3;
  localparam int EXT_MIN_PULSE_NS = 200;
  localparam int BRN_FILTER_NS = 100;
  localparam logic [4:0] EXT_MIN_CYC = 5'((EXT_MIN_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] BRN_FILTER_CYC = 5'((BRN_FILTER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] TOUT_SEL0_CYC = 16'h0010;
  localparam logic [15:0] TOUT_SEL1_CYC = 16'h0040;
  localparam logic [15:0] TOUT_SEL2_CYC = 16'h0100;
  localparam logic [15:0] TOUT_SEL3_CYC = 16'h1000;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    SM_IDLE = 2'h0,
    SM_NOISE_RED = 2'h1,
    SM_POWER_DOWN = 2'h2,
    SM_STANDBY = 2'h3
  } psr_sleep_mode_t;
  typedef enum logic [1:0] {
    ST_AWAKE = 2'h0,
    ST_ASLEEP = 2'h1,
    ST_WAKING = 2'h3
  } psr_pwr_state_t;
  typedef struct packed {
    logic timer1;
    logic timer0;
    logic serial;
    logic converter;
  } psr_gate_t;
  typedef struct packed {
    logic power_on;
    logic external;
    logic watchdog;
    logic brownout;
  } psr_rst_src_t;

  function automatic logic [15:0] psr_tout(input logic [1:0] sel);
    case (sel)
      2'h0: psr_tout = TOUT_SEL0_CYC;
      2'h1: psr_tout = TOUT_SEL1_CYC;
      2'h2: psr_tout = TOUT_SEL2_CYC;
      default: psr_tout = TOUT_SEL3_CYC;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: src/psr_reset_stretch.sv
/*
  Reset delay counter: holds the internal reset while any source is active
  and for a selectable number of cycles after the last one goes away.
  Assumes hold comes from logic on the same clock.
*/
`default_nettype none
module psr_reset_stretch (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [15:0] tout_cycles,
  output logic stretch_active
);
  // ==========================================================================
  // Counter
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic active_q;
  wire logic cnt_busy = (cnt_q != 16'h0000);

  assign cnt_d = hold ? tout_cycles : (cnt_busy ? cnt_q - 16'h0001 : cnt_q);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      active_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      active_q <= hold | cnt_busy;
    end
  end

  assign stretch_active = active_q;
endmodule // psr_reset_stretch
`default_nettype wire

// file: src/psr_ctrl.sv
/*
  Power, sleep and reset control: sleep control register with the timed
  brownout-off sequence, module clock gating register, reset source
  combining, reset stretching and the internal reference enable.
  Assumes the CPU core sits on mclk and pulses sleep_instr for the sleep
  instruction; fuse inputs are static; reset pins arrive asynchronously.
*/
// Chosen here: the Avalon-MM register port.
`default_nettype none
// Summary of operation
// - Off bit active after three, clears after three
// - Detector off only if sleeping inside window
// - Sleep only when sleep enable is set
// - Mode field: idle, noise, power-down, standby
// - Unlock bit gates setting of off bit
// - Gating register upper nibble reads zero
// - Gate bit 3 freezes timer 1
// - Gate bit 2 freezes timer 0
// - Gate bit 1 stops serial unit clock
// - Gate bit 0 stops converter clock
// - Reset loads register initial values, then fetch
// - Port reset is immediate, needs no clock
// - Delay counter stretches reset by fuse time
// - Four reset sources combine into internal reset
// - Long external low pulse causes reset
// - Filtered brownout resets at once, stretched release
// - Watchdog pulse one cycle, delay starts after
// - Reference on for detector, bandgap or converter
// - Gated module frozen, its registers blocked
module psr_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_instr,
  input wire logic wake_event,
  output logic sleep_active,
  output psr_pkg::psr_sleep_mode_t sleep_mode,
  output logic brn_disabled,
  output psr_pkg::psr_gate_t clock_gate,
  output psr_pkg::psr_gate_t periph_access_en,
  input wire logic por_n,
  input wire logic ext_reset_pin_n,
  input wire logic brownout_low,
  input wire logic brownout_fuse_enable,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout,
  input wire logic [1:0] startup_time_fuse,
  input wire logic comparator_bandgap_select,
  input wire logic converter_enable,
  output logic ref_enable,
  output logic io_reset_async,
  output logic int_reset,
  output psr_pkg::psr_rst_src_t reset_src,
  output logic fetch_reset_vector
);
  // ==========================================================================
  // Pin synchronisers: por_n, ext_reset_pin_n, brownout_low
  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  assign pin_raw = {por_n, ext_reset_pin_n, brownout_low};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // Por resets to not-good so reset is stretched; the external pin
      // resets to its idle high level, else a false low follows reset
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          sync1_q[gi] <= psr_pkg::PIN_SYNC_RESET[gi];
          sync2_q[gi] <= psr_pkg::PIN_SYNC_RESET[gi];
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire logic por_ok_s = sync2_q[2];
  wire logic ext_low_s = ~sync2_q[1];
  wire logic brn_low_s = sync2_q[0] & brownout_fuse_enable;

  // ==========================================================================
  // Reset sources
  logic [4:0] ext_cnt_q;
  logic [4:0] brn_cnt_q;
  logic wdt_prev_q;
  logic wdt_pulse_q;
  logic int_reset_d_q;
  logic stretch_active;
  logic brn_off_q;
  psr_pkg::psr_rst_src_t src;
  psr_pkg::psr_rst_src_t src_q;

  wire logic ext_hit = (ext_cnt_q == psr_pkg::EXT_MIN_CYC);
  wire logic brn_hit = (brn_cnt_q == psr_pkg::BRN_FILTER_CYC) & ~brn_off_q;
  wire logic wdt_hit = watchdog_timeout & watchdog_enable;

  // Short glitches on the pin never reach the counter end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_cnt_q <= 5'h00;
    end else if (!ext_low_s) begin
      ext_cnt_q <= 5'h00;
    end else if (!ext_hit) begin
      ext_cnt_q <= ext_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      brn_cnt_q <= 5'h00;
    end else if (!brn_low_s) begin
      brn_cnt_q <= 5'h00;
    end else if (brn_cnt_q != psr_pkg::BRN_FILTER_CYC) begin
      brn_cnt_q <= brn_cnt_q + 5'h01;
    end
  end

  // One cycle pulse per time-out, even if the request is held longer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wdt_prev_q <= 1'b0;
      wdt_pulse_q <= 1'b0;
    end else begin
      wdt_prev_q <= wdt_hit;
      wdt_pulse_q <= wdt_hit & ~wdt_prev_q;
    end
  end

  assign src.power_on = ~por_ok_s;
  assign src.external = ext_hit;
  assign src.watchdog = wdt_pulse_q;
  assign src.brownout = brn_hit;
  wire logic src_any = |src;

  // Delay counts from the cycle after the watchdog pulse falls
  psr_reset_stretch u_stretch (
    .mclk(mclk),
    .rst_n(rst_n),
    .hold(src_any),
    .tout_cycles(psr_pkg::psr_tout(startup_time_fuse)),
    .stretch_active(stretch_active)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_q <= '0;
      int_reset_d_q <= 1'b1;
    end else begin
      src_q <= src;
      int_reset_d_q <= stretch_active;
    end
  end

  // Raw pins on purpose: ports must let go with no clock running
  assign io_reset_async = ~por_n | ~ext_reset_pin_n |
                          (brownout_low & brownout_fuse_enable & ~brn_off_q);
  assign int_reset = stretch_active;
  assign reset_src = src_q;
  assign fetch_reset_vector = int_reset_d_q & ~stretch_active;
  wire logic clr = ~rst_n | stretch_active;

  // ==========================================================================
  // Avalon-MM slave, one wait state per access
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] psc_q;
  logic [7:0] mcg_q;
  logic unlock_q;
  logic [2:0] window_q;
  logic [2:0] off_age_q;

  wire logic req = avs_read | avs_write;
  // A write with lane 0 off is acknowledged and dropped
  wire logic wr_take = avs_write & ack_q & avs_byteenable[0];
  wire logic hit_psc = (avs_address == psr_pkg::PSC_ADDR);
  wire logic hit_mcg = (avs_address == psr_pkg::MCG_ADDR);
  wire logic psc_wr = wr_take & hit_psc & ~clr;
  wire logic mcg_wr = wr_take & hit_mcg & ~clr;
  wire logic [7:0] wd = avs_writedata[7:0];
  wire logic off_bit = (off_age_q != 3'h0);
  wire logic [7:0] psc_rd = {off_bit, psc_q[6:3], unlock_q, psc_q[1:0]};
  wire logic [7:0] mcg_rd = mcg_q & psr_pkg::MCG_WR_MASK;
  wire logic [7:0] rd_mux = hit_psc ? psc_rd : (hit_mcg ? mcg_rd : 8'h00);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  // ==========================================================================
  // Control register and timed brownout-off sequence
  wire logic arm = psc_wr & wd[psr_pkg::PSC_BRN_OFF_BIT] & wd[psr_pkg::PSC_UNLOCK_BIT];
  wire logic win_open = (window_q != 3'h0);
  wire logic commit = psc_wr & wd[psr_pkg::PSC_BRN_OFF_BIT] &
                      ~wd[psr_pkg::PSC_UNLOCK_BIT] & win_open;
  // Off bit lives six cycles; only the last three count for sleep
  wire logic off_last = (off_age_q == psr_pkg::BRN_OFF_DELAY_CYC + psr_pkg::BRN_OFF_HOLD_CYC);
  wire logic off_active = (off_age_q > psr_pkg::BRN_OFF_DELAY_CYC);

  always_ff @(posedge mclk) begin
    if (clr) begin
      psc_q <= psr_pkg::PSC_RESET;
    end else if (psc_wr) begin
      psc_q <= wd & psr_pkg::PSC_PLAIN_MASK;
    end
  end

  // Arming wins over the window running out in the same cycle
  always_ff @(posedge mclk) begin
    if (clr) begin
      window_q <= 3'h0;
      unlock_q <= 1'b0;
    end else if (arm) begin
      window_q <= psr_pkg::BRN_OFF_WINDOW_CYC;
      unlock_q <= 1'b1;
    end else if (commit) begin
      window_q <= 3'h0;
      unlock_q <= 1'b0;
    end else if (win_open) begin
      window_q <= window_q - 3'h1;
      unlock_q <= (window_q != 3'h1);
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      off_age_q <= 3'h0;
    end else if (commit) begin
      off_age_q <= 3'h1;
    end else if (off_last) begin
      off_age_q <= 3'h0;
    end else if (off_bit) begin
      off_age_q <= off_age_q + 3'h1;
    end
  end

  // ==========================================================================
  // Sleep control
  psr_pkg::psr_pwr_state_t state_q;
  psr_pkg::psr_pwr_state_t state_d;
  psr_pkg::psr_sleep_mode_t mode_q;
  wire psr_pkg::psr_sleep_mode_t mode_sel =
    psr_pkg::psr_sleep_mode_t'(psc_q[psr_pkg::PSC_SM_HI:psr_pkg::PSC_SM_LO]);
  // Only power-down and standby may drop the detector
  wire logic deep_mode = (mode_sel == psr_pkg::SM_POWER_DOWN) |
                         (mode_sel == psr_pkg::SM_STANDBY);
  wire logic go_sleep = sleep_instr & psc_q[psr_pkg::PSC_SLEEP_EN_BIT];

  always_comb begin
    state_d = state_q;
    case (state_q)
      psr_pkg::ST_AWAKE: begin
        if (go_sleep) begin
          state_d = psr_pkg::ST_ASLEEP;
        end
      end
      psr_pkg::ST_ASLEEP: begin
        if (wake_event) begin
          state_d = psr_pkg::ST_WAKING;
        end
      end
      psr_pkg::ST_WAKING: begin
        state_d = psr_pkg::ST_AWAKE;
      end
      default: begin
        state_d = psr_pkg::ST_AWAKE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      state_q <= psr_pkg::ST_AWAKE;
      mode_q <= psr_pkg::SM_IDLE;
    end else begin
      state_q <= state_d;
      if (state_q == psr_pkg::ST_AWAKE && go_sleep) begin
        mode_q <= mode_sel;
      end
    end
  end

  // Detector comes back as the waking state ends
  always_ff @(posedge mclk) begin
    if (clr) begin
      brn_off_q <= 1'b0;
    end else if (state_q == psr_pkg::ST_AWAKE && go_sleep) begin
      brn_off_q <= off_active & deep_mode;
    end else if (state_q != psr_pkg::ST_ASLEEP) begin
      brn_off_q <= 1'b0;
    end
  end

  assign sleep_active = (state_q != psr_pkg::ST_AWAKE);
  assign sleep_mode = mode_q;
  assign brn_disabled = brn_off_q;

  // ==========================================================================
  // Module clock gating and reference enable
  always_ff @(posedge mclk) begin
    if (clr) begin
      mcg_q <= psr_pkg::MCG_RESET;
    end else if (mcg_wr) begin
      mcg_q <= wd & psr_pkg::MCG_WR_MASK;
    end
  end

  // Gating is an enable, so a module holds its state and resumes as it was
  assign clock_gate.timer1 = mcg_q[psr_pkg::MCG_TIMER1_BIT];
  assign clock_gate.timer0 = mcg_q[psr_pkg::MCG_TIMER0_BIT];
  assign clock_gate.serial = mcg_q[psr_pkg::MCG_SERIAL_BIT];
  assign clock_gate.converter = mcg_q[psr_pkg::MCG_CONV_BIT];
  assign periph_access_en = ~clock_gate;

  // Start-up wait is left to software
  assign ref_enable = brownout_fuse_enable | comparator_bandgap_select |
                      converter_enable;
endmodule // psr_ctrl
`default_nettype wire

// file: verif/psr_cpu_model.sv
/*
  CPU-side model: sleep instruction, wake-up cause and watchdog time-out strobes.
  Assumes each call starts just after a rising edge of mclk.
*/
`default_nettype none
module psr_cpu_model (
  input wire logic mclk,
  output logic sleep_instr,
  output logic wake_event,
  output logic watchdog_timeout
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sleep_instr = 1'b0;
    wake_event = 1'b0;
    watchdog_timeout = 1'b0;
  end
  // One-cycle strobes, like a single instruction or time-out
  task automatic pulse(input int which);
    case (which)
      0: sleep_instr <= 1'b1;
      1: wake_event <= 1'b1;
      default: watchdog_timeout <= 1'b1;
    endcase
    @(posedge mclk);
    sleep_instr <= 1'b0;
    wake_event <= 1'b0;
    watchdog_timeout <= 1'b0;
  endtask
endmodule // psr_cpu_model
`default_nettype wire

// file: verif/psr_ctrl_chk.sv
/*
  Port checker for psr_ctrl.
  Assumes it is bound to every psr_ctrl instance.
*/
`default_nettype none
module psr_ctrl_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sleep_instr,
  input wire logic sleep_active,
  input wire psr_pkg::psr_sleep_mode_t sleep_mode,
  input wire logic brn_disabled,
  input wire psr_pkg::psr_gate_t clock_gate,
  input wire logic por_n,
  input wire logic ext_reset_pin_n,
  input wire logic brownout_fuse_enable,
  input wire logic comparator_bandgap_select,
  input wire logic converter_enable,
  input wire logic ref_enable,
  input wire logic io_reset_async,
  input wire logic int_reset,
  input wire psr_pkg::psr_rst_src_t reset_src,
  input wire logic fetch_reset_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] quiet_q;
  logic [7:0] quiet_d;
  wire logic mcg_hit = avs_address == psr_pkg::MCG_ADDR && !avs_waitrequest;
  wire logic wr_mcg = mcg_hit && avs_write && avs_byteenable[0];
  wire logic rd_mcg = mcg_hit && avs_read;
  // Cycles of internal reset with no source left: the stretch
  assign quiet_d = (quiet_q == 8'hff) ? quiet_q : quiet_q + 8'h01;
  always_ff @(posedge mclk)
    quiet_q <= (!rst_n || reset_src != 4'h0 || !int_reset) ? 8'h00 : quiet_d;
  // ==========================================================================
  // Properties
  property p_ref;
    ref_enable == (brownout_fuse_enable || comparator_bandgap_select || converter_enable);
  endproperty
  property p_gate;
    wr_mcg && !int_reset |=> clock_gate == $past(avs_writedata[3:0]);
  endproperty
  property p_rd;
    rd_mcg |-> avs_readdata[31:4] == 28'h0;
  endproperty
  property p_sleep;
    $rose(sleep_active) |-> $past(sleep_instr);
  endproperty
  property p_brn_off;
    brn_disabled |-> sleep_active && sleep_mode[1];
  endproperty
  property p_wd;
    $rose(reset_src.watchdog) |=> !reset_src.watchdog;
  endproperty
  property p_src;
    reset_src != 4'h0 |-> ##[0:1] int_reset;
  endproperty
  property p_stretch;
    $fell(int_reset) |-> quiet_q >= 8'h0f;
  endproperty
  property p_fetch;
    $fell(int_reset) |-> ##[0:1] fetch_reset_vector ##1 !fetch_reset_vector;
  endproperty
  property p_io;
    !por_n || !ext_reset_pin_n |-> io_reset_async;
  endproperty
  a_ref: assert property (p_ref) else $error("ref enable");
  a_gate: assert property (p_gate) else $error("gate");
  a_rd: assert property (p_rd) else $error("gate read");
  a_sleep: assert property (p_sleep) else $error("sleep");
  a_brn_off: assert property (p_brn_off) else $error("detector off");
  a_wd: assert property (p_wd) else $error("wd pulse");
  a_src: assert property (p_src) else $error("src");
  a_stretch: assert property (p_stretch) else $error("stretch");
  a_fetch: assert property (p_fetch) else $error("fetch");
  a_io: assert property (p_io) else $error("io reset");
  c_brn_off: cover property (brn_disabled);
  c_wd: cover property ($rose(reset_src.watchdog));
  c_rel: cover property ($fell(int_reset));
endmodule // psr_ctrl_chk
bind psr_ctrl psr_ctrl_chk chk (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .sleep_instr,
  .sleep_active, .sleep_mode, .brn_disabled, .clock_gate, .por_n, .ext_reset_pin_n,
  .brownout_fuse_enable, .comparator_bandgap_select, .converter_enable, .ref_enable,
  .io_reset_async, .int_reset, .reset_src, .fetch_reset_vector);
`default_nettype wire

// file: verif/psr_ctrl_tb_top.sv
/*
  Self-checking bench for psr_ctrl: registers, sleep, gating, reset, reference.
  Assumes psr_cpu_model on the CPU side and the bound checker.
*/
`default_nettype none
module psr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] PSC = psr_pkg::PSC_ADDR;
  localparam logic [9:0] MCG = psr_pkg::MCG_ADDR;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, sleep_instr, wake_event;
  logic sleep_active, brn_disabled, por_n, ext_reset_pin_n, brownout_low;
  logic brownout_fuse_enable, watchdog_enable, watchdog_timeout, converter_enable;
  logic comparator_bandgap_select, ref_enable, io_reset_async, int_reset;
  logic fetch_reset_vector;
  logic [9:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] startup_time_fuse;
  psr_pkg::psr_sleep_mode_t sleep_mode;
  psr_pkg::psr_gate_t clock_gate, periph_access_en;
  psr_pkg::psr_rst_src_t reset_src;
  logic [3:0] exp_src [4] = '{4'h4, 4'h1, 4'h2, 4'h8};
  logic [3:0] seen;
  logic [7:0] q;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  psr_ctrl uut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .sleep_instr, .wake_event,
    .sleep_active, .sleep_mode, .brn_disabled, .clock_gate, .periph_access_en, .por_n,
    .ext_reset_pin_n, .brownout_low, .brownout_fuse_enable, .watchdog_enable,
    .watchdog_timeout, .startup_time_fuse, .comparator_bandgap_select, .converter_enable,
    .ref_enable, .io_reset_async, .int_reset, .reset_src, .fetch_reset_vector);
  psr_cpu_model cpu (.mclk, .sleep_instr, .wake_event, .watchdog_timeout);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================================
  // Tasks
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Request is left up so a following access needs no gap edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata[7:0];
    if (k >= 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic rel;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input string nm, input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    rel();
    chk(nm, q, e);
  endtask
  task automatic wrst(inout int hi);
    int k;
    k = 0;
    while (int_reset !== 1'b0 && k < 300) begin
      @(posedge mclk);
      hi++;
      k++;
    end
    if (k >= 300) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  // Sleep is issued at off-bit age d+2 after the commit write
  task automatic slp(input logic [7:0] v, input int d, input logic ea, input logic eb);
    if (v[7]) bus(1'b1, PSC, v | 8'h04);
    bus(1'b1, PSC, v);
    rel();
    repeat (d) @(posedge mclk);
    cpu.pulse(0);
    @(posedge mclk);
    chk("sleep_active", sleep_active, ea);
    chk("brn_disabled", brn_disabled, eb);
    if (ea) chk("sleep_mode", sleep_mode, v[4:3]);
    cpu.pulse(1);
    repeat (3) @(posedge mclk);
    chk("awake", sleep_active, 1'b0);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    {rst_n, avs_read, avs_write, brownout_low, comparator_bandgap_select} = 5'h00;
    {avs_address, avs_writedata, startup_time_fuse, converter_enable} = '0;
    {por_n, ext_reset_pin_n, brownout_fuse_enable, watchdog_enable} = 4'hf;
    avs_byteenable = 4'h1;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    n = 0;
    wrst(n);
    chk("tout", n >= 16, 1'b1);
    rd_chk("psc_init", PSC, 8'h00);
    rd_chk("mcg_init", MCG, 8'h00);
    bus(1'b1, 10'h100, 8'hff);
    rel();
    rd_chk("unmapped", 10'h100, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, MCG, 8'hf0 | (8'h01 << i));
      rel();
      rd_chk("mcg", MCG, 8'h01 << i);
      chk("gate", clock_gate, 4'h1 << i);
      chk("access", periph_access_en, 4'hf ^ (4'h1 << i));
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, MCG, 8'h0f);
    rel();
    avs_byteenable <= 4'h1;
    rd_chk("lane0_off", MCG, 8'h08);
    bus(1'b1, PSC, 8'h80);
    rel();
    rd_chk("no_arm", PSC, 8'h00);
    bus(1'b1, PSC, 8'h84);
    rel();
    repeat (6) @(posedge mclk);
    bus(1'b1, PSC, 8'h80);
    rel();
    rd_chk("late", PSC, 8'h00);
    for (int i = 0; i < 4; i++) slp(8'h20 | 8'(i << 3), 0, 1'b1, 1'b0);
    slp(8'h10, 0, 1'b0, 1'b0);
    slp(8'hb0, 0, 1'b1, 1'b0);
    slp(8'hb0, 3, 1'b1, 1'b1);
    slp(8'hb8, 3, 1'b1, 1'b1);
    slp(8'ha8, 3, 1'b1, 1'b0);
    rd_chk("off_clr", PSC, 8'h28);
    ext_reset_pin_n <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("io_rst", io_reset_async, 1'b1);
    ext_reset_pin_n <= 1'b1;
    repeat (30) @(posedge mclk);
    chk("short", int_reset, 1'b0);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, MCG, 8'h0a);
      rel();
      n = 0;
      seen = 4'h0;
      case (s)
        0: ext_reset_pin_n <= 1'b0;
        1: brownout_low <= 1'b1;
        2: cpu.pulse(2);
        default: por_n <= 1'b0;
      endcase
      repeat (30) begin
        @(posedge mclk);
        seen = seen | reset_src;
        n += int'(int_reset);
      end
      {ext_reset_pin_n, brownout_low, por_n} <= 3'h5;
      wrst(n);
      chk("src", seen, exp_src[s]);
      chk("hold", n >= 16, 1'b1);
      rd_chk("cleared", MCG, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      {brownout_fuse_enable, comparator_bandgap_select, converter_enable} <= 3'(i);
      repeat (2) @(posedge mclk);
      chk("ref", ref_enable, i != 0);
    end
    tally_and_finish();
  end
endmodule // psr_ctrl_tb_top
`default_nettype wire
